//--- shared/msc_defs.svh
/*
 Constants for the memory size configuration register bank: addresses,
 field positions, reset values and capacity codes.
 Assumes inclusion by bare name from the design files.
*/
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH

`define MSC_ADDR_MEM_CFG     16'hFFF0
`define MSC_ADDR_EXT_CFG     16'hFFF4
`define MSC_RST_MEM_CFG      8'hCF
`define MSC_RST_EXT_CFG      8'h0C

`define MSC_HS_MSB           7
`define MSC_HS_LSB           5
`define MSC_ZERO_BIT         4
`define MSC_PM_MSB           3
`define MSC_PM_LSB           0
`define MSC_EXT_MSB          4
`define MSC_EXT_LSB          0

`define MSC_HS_1K            3'h6
`define MSC_PM_32K           4'h8
`define MSC_PM_48K           4'hC
`define MSC_PM_60K           4'hF
`define MSC_EXT_1K           5'h0A
`define MSC_EXT_2K           5'h08

`endif

//--- shared/msc_pkg.sv
/*
 Types for the memory size configuration register bank.
 Assumes msc_defs.svh is compiled alongside.
*/
package msc_pkg;

    typedef enum logic [3:0] {
        MSC_PM_NONE = 4'h1,
        MSC_PM_32K  = 4'h2,
        MSC_PM_48K  = 4'h4,
        MSC_PM_60K  = 4'h8
    } msc_pm_e;

    typedef struct packed {
        logic [7:0] memCfg;
        logic [7:0] extCfg;
    } msc_state_s;

endpackage

//--- core/msc_byte_reg.sv
/*
 One 8-bit software register with a write mask for bits that read as zero.
 Assumes writes arrive as whole bytes on the system clock.
*/
`timescale 1ns/1ps
`include "msc_defs.svh"

module msc_byte_reg #(
    parameter logic [15:0] ADDR     = 16'h0000,
    parameter logic [7:0]  RST_VAL  = 8'h00,
    parameter logic [7:0]  KEEP_MSK = 8'hFF
) (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        wrEn,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wrData,
    output logic      [7:0]  value_r
);
    logic [7:0] value_nxt;

    always_comb begin
        value_nxt = value_r;
        if (wrEn && addr == ADDR) begin
            value_nxt = wrData & KEEP_MSK;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            value_r <= RST_VAL;
        end else begin
            value_r <= value_nxt;
        end
    end
endmodule

//--- core/memory_size_config_regs.sv
/*
 Memory size configuration register bank: the memory size register and the
 expansion RAM size register, with decoded capacity selections.
 Assumes a CPU-side byte port on mclk: one write strobe, one read strobe,
 16-bit address; read data returns one cycle after the read strobe.
*/
`timescale 1ns/1ps
`include "msc_defs.svh"

module memory_size_config_regs (
    input  wire logic                 mclk,
    input  wire logic                 nrst,
    input  wire logic                 wrEn,
    input  wire logic                 rdEn,
    input  wire logic [15:0]          addr,
    input  wire logic [7:0]           wrData,
    output logic      [7:0]           rdData,
    output logic                      rdHit,
    output logic                      hsMem1k,
    output msc_pkg::msc_pm_e          progMemSel,
    output logic                      extMem1k,
    output logic                      extMem2k,
    output logic      [7:0]           memCfgOut,
    output logic      [7:0]           extCfgOut
);
    localparam logic [7:0] MEM_KEEP = ~(8'h01 << `MSC_ZERO_BIT);
    localparam logic [7:0] EXT_KEEP = 8'h1F;

    typedef struct packed {
        logic [7:0]       rdData;
        logic             rdHit;
        logic             hsMem1k;
        msc_pkg::msc_pm_e progMemSel;
        logic             extMem1k;
        logic             extMem2k;
    } msc_out_s;

    msc_out_s st_r;
    msc_out_s st_nxt;
    logic [7:0] memCfg_r;
    logic [7:0] extCfg_r;

    // Memory size register, bit 4 forced to zero
    msc_byte_reg #(
        .ADDR     (`MSC_ADDR_MEM_CFG),
        .RST_VAL  (`MSC_RST_MEM_CFG),
        .KEEP_MSK (MEM_KEEP)
    ) uMemCfg (
        .mclk    (mclk),
        .nrst    (nrst),
        .wrEn    (wrEn),
        .addr    (addr),
        .wrData  (wrData),
        .value_r (memCfg_r)
    );

    // Expansion register, whole-byte writes only, top bits zero
    msc_byte_reg #(
        .ADDR     (`MSC_ADDR_EXT_CFG),
        .RST_VAL  (`MSC_RST_EXT_CFG),
        .KEEP_MSK (EXT_KEEP)
    ) uExtCfg (
        .mclk    (mclk),
        .nrst    (nrst),
        .wrEn    (wrEn),
        .addr    (addr),
        .wrData  (wrData),
        .value_r (extCfg_r)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.rdHit = 1'b0;
        st_nxt.rdData = 8'h00;
        if (rdEn && addr == `MSC_ADDR_MEM_CFG) begin
            st_nxt.rdData = memCfg_r;
            st_nxt.rdHit = 1'b1;
        end else if (rdEn && addr == `MSC_ADDR_EXT_CFG) begin
            st_nxt.rdData = extCfg_r;
            st_nxt.rdHit = 1'b1;
        end
        // Decode from current contents
        st_nxt.hsMem1k = (memCfg_r[`MSC_HS_MSB:`MSC_HS_LSB]
                          == `MSC_HS_1K);
        case (memCfg_r[`MSC_PM_MSB:`MSC_PM_LSB])
            `MSC_PM_32K: begin
                st_nxt.progMemSel = msc_pkg::MSC_PM_32K;
            end
            `MSC_PM_48K: begin
                st_nxt.progMemSel = msc_pkg::MSC_PM_48K;
            end
            `MSC_PM_60K: begin
                st_nxt.progMemSel = msc_pkg::MSC_PM_60K;
            end
            default: begin
                st_nxt.progMemSel = msc_pkg::MSC_PM_NONE;
            end
        endcase
        st_nxt.extMem1k = (extCfg_r[`MSC_EXT_MSB:`MSC_EXT_LSB]
                           == `MSC_EXT_1K);
        st_nxt.extMem2k = (extCfg_r[`MSC_EXT_MSB:`MSC_EXT_LSB]
                           == `MSC_EXT_2K);
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r.rdData     <= 8'h00;
            st_r.rdHit      <= 1'b0;
            st_r.hsMem1k    <= 1'b1;
            st_r.progMemSel <= msc_pkg::MSC_PM_60K;
            st_r.extMem1k   <= 1'b0;
            st_r.extMem2k   <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdData     = st_r.rdData;
    assign rdHit      = st_r.rdHit;
    assign hsMem1k    = st_r.hsMem1k;
    assign progMemSel = st_r.progMemSel;
    assign extMem1k   = st_r.extMem1k;
    assign extMem2k   = st_r.extMem2k;
    assign memCfgOut  = memCfg_r;
    assign extCfgOut  = extCfg_r;

    sequence s_memWrite;
        wrEn && addr == `MSC_ADDR_MEM_CFG;
    endsequence

    sequence s_extWrite;
        wrEn && addr == `MSC_ADDR_EXT_CFG;
    endsequence

    a_mem_write_store: assert property (
        @(posedge mclk) disable iff (!nrst)
        s_memWrite |=> memCfg_r == ($past(wrData) & 8'hEF))
        else $error("memory size write not stored");

    a_mem_bit4_zero: assert property (
        @(posedge mclk) disable iff (!nrst)
        memCfg_r[4] == 1'b0)
        else $error("memory size bit 4 not zero");

    a_ext_write_store: assert property (
        @(posedge mclk) disable iff (!nrst)
        s_extWrite |=> extCfg_r == ($past(wrData) & 8'h1F))
        else $error("expansion size write not stored");

    a_ext_top_zero: assert property (
        @(posedge mclk) disable iff (!nrst)
        extCfg_r[7:5] == 3'h0)
        else $error("expansion size top bits not zero");

    a_hs_decode: assert property (
        @(posedge mclk) disable iff (!nrst)
        s_memWrite ##1 !wrEn |=> hsMem1k == ($past(wrData, 2) >> 5 == 8'h06))
        else $error("high-speed size decode wrong");

    a_pm_decode: assert property (
        @(posedge mclk) disable iff (!nrst)
        memCfg_r[3:0] == 4'hC |=> progMemSel == msc_pkg::MSC_PM_48K)
        else $error("program memory decode wrong");

    a_ext_decode: assert property (
        @(posedge mclk) disable iff (!nrst)
        extCfg_r[4:0] == 5'h08 |=> extMem2k && !extMem1k)
        else $error("expansion decode wrong");

    a_read_back: assert property (
        @(posedge mclk) disable iff (!nrst)
        (rdEn && addr == `MSC_ADDR_EXT_CFG) |=>
        rdHit && rdData == $past(extCfg_r))
        else $error("expansion read-back wrong");
endmodule

//--- tb/test_memory_size_config_regs.sv
/*
 Self-checking bench for the memory size configuration register bank.
 Assumes the design files, msc_pkg and msc_defs.svh are compiled first.
*/
`timescale 1ns/1ps
`include "msc_defs.svh"
`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin \
    numErrors++; $display("ERROR %0t got %h expected %h", $time, got, exp); \
    end end

module test_memory_size_config_regs;
    logic             mclk;
    logic             nrst;
    logic             wrEn;
    logic             rdEn;
    logic [15:0]      addr;
    logic [7:0]       wrData;
    logic [7:0]       rdData;
    logic             rdHit;
    logic             hsMem1k;
    msc_pkg::msc_pm_e progMemSel;
    logic             extMem1k;
    logic             extMem2k;
    logic [7:0]       memCfgOut;
    logic [7:0]       extCfgOut;
    logic [7:0]       memExp;
    logic [7:0]       extExp;
    logic [15:0]      a;
    int               numErrors;
    int               testsRun;

    memory_size_config_regs dut_u (
        .mclk(mclk), .nrst(nrst), .wrEn(wrEn), .rdEn(rdEn), .addr(addr),
        .wrData(wrData), .rdData(rdData), .rdHit(rdHit), .hsMem1k(hsMem1k),
        .progMemSel(progMemSel), .extMem1k(extMem1k), .extMem2k(extMem2k),
        .memCfgOut(memCfgOut), .extCfgOut(extCfgOut));

    function automatic msc_pkg::msc_pm_e pmOf(input logic [3:0] c);
        case (c)
            `MSC_PM_32K: return msc_pkg::MSC_PM_32K;
            `MSC_PM_48K: return msc_pkg::MSC_PM_48K;
            `MSC_PM_60K: return msc_pkg::MSC_PM_60K;
            default:     return msc_pkg::MSC_PM_NONE;
        endcase
    endfunction

    task chkRegs;
        `CHK(memCfgOut, memExp)
        `CHK(extCfgOut, extExp)
    endtask

    task chkDec;
        `CHK(hsMem1k, memExp[7:5] == `MSC_HS_1K)
        `CHK(progMemSel, pmOf(memExp[3:0]))
        `CHK(extMem1k, extExp[4:0] == `MSC_EXT_1K)
        `CHK(extMem2k, extExp[4:0] == `MSC_EXT_2K)
    endtask

    task automatic wr(input logic [15:0] wa, input logic [7:0] d);
        @(posedge mclk);
        wrEn <= 1'b1;
        addr <= wa;
        wrData <= d;
        @(posedge mclk);
        wrEn <= 1'b0;
        if (wa == `MSC_ADDR_MEM_CFG) memExp = d & 8'hEF;
        else if (wa == `MSC_ADDR_EXT_CFG) extExp = d & 8'h1F;
        #1;
        chkRegs();
        @(posedge mclk);
        #1;
        chkDec();
    endtask

    task automatic rd(input logic [15:0] ra);
        logic       hit;
        logic [7:0] d;
        hit = (ra == `MSC_ADDR_MEM_CFG) || (ra == `MSC_ADDR_EXT_CFG);
        d = (ra == `MSC_ADDR_MEM_CFG) ? memExp :
            (ra == `MSC_ADDR_EXT_CFG) ? extExp : 8'h00;
        @(posedge mclk);
        rdEn <= 1'b1;
        addr <= ra;
        @(posedge mclk);
        rdEn <= 1'b0;
        #1;
        `CHK(rdHit, hit)
        `CHK(rdData, d)
    endtask

    task testDone;
        if (numErrors == 0 && testsRun > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    initial begin
        #(50 * 10000);
        numErrors++;
        testDone();
    end

    initial begin
        nrst = 1'b0;
        wrEn = 1'b0;
        rdEn = 1'b0;
        addr = 16'h0000;
        wrData = 8'h00;
        numErrors = 0;
        testsRun = 0;
        memExp = `MSC_RST_MEM_CFG;
        extExp = `MSC_RST_EXT_CFG;
        void'($urandom(32'hFB2D9BC7));
        repeat (5) @(posedge mclk);
        #1;
        chkRegs();
        chkDec();
        @(posedge mclk);
        nrst <= 1'b1;
        rd(`MSC_ADDR_MEM_CFG);
        rd(`MSC_ADDR_EXT_CFG);
        rd(16'hFFF1);
        // Every code of each field, with masked bits written high
        for (int i = 0; i < 16; i++) begin
            wr(`MSC_ADDR_MEM_CFG, {(i[0] ? 3'h6 : i[3:1]), 1'b1, i[3:0]});
        end
        for (int i = 0; i < 32; i++) begin
            wr(`MSC_ADDR_EXT_CFG, {3'h7, i[4:0]});
        end
        // Variant settings, memory register first
        wr(`MSC_ADDR_MEM_CFG, 8'hC8);
        wr(`MSC_ADDR_EXT_CFG, 8'h0A);
        wr(`MSC_ADDR_MEM_CFG, 8'hCF);
        wr(`MSC_ADDR_EXT_CFG, 8'h08);
        repeat (200) begin
            case ($urandom % 3)
                0:       a = `MSC_ADDR_MEM_CFG;
                1:       a = `MSC_ADDR_EXT_CFG;
                default: a = 16'($urandom);
            endcase
            wr(a, 8'($urandom));
            if ($urandom % 4 == 0) rd(a);
        end
        // Reset in mid-run restores both registers
        @(posedge mclk);
        nrst <= 1'b0;
        #1;
        memExp = `MSC_RST_MEM_CFG;
        extExp = `MSC_RST_EXT_CFG;
        chkRegs();
        chkDec();
        @(posedge mclk);
        nrst <= 1'b1;
        rd(`MSC_ADDR_MEM_CFG);
        rd(`MSC_ADDR_EXT_CFG);
        testDone();
    end
endmodule
